// ===== src/epk_pkg.sv
// Functional notes
// R1 - crc engine ignores every security lock; it always runs when asked (the code drops a start written while a crc is busy)
// R2 - two jobs: 16-bit crc over one block, 32-bit crc over all memory
// R3 - block start is always high byte with low byte 0x00, length 256
// R4 - debug write of crc byte 1 starts the full-memory 32-bit crc
// R5 - full crc runs from address 0x0000 through the last user location
// R6 - busy flag in debug address register is high for the whole crc run
// R7 - 32-bit result: byte 3 most significant, byte 0 least significant
// R8 - 32-bit generator polynomial is 0x04C11DB7
// R9 - adapter should reset the device before a 32-bit crc after a 16-bit one
// R10 - debug write of crc byte 0 gives the block's upper address byte
// R11 - 16-bit result sits in crc bytes 1 (msb) and 0 (lsb)
// R12 - 16-bit generator polynomial is 0x1021
// R13 - write enable bit routes move writes to program memory, else blocked
// R14 - upper seven bits of program store control read zero, writes ignored
// R15 - key 0xA5 then 0xF1 unlocks program memory writes
// R16 - after one unlocked program write the lock closes again by itself
// R17 - bad key, wrong order or write while locked disables until reset
// R18 - key register read: 00 locked, 01 first key, 10 unlocked, 11 disabled
// R19 - crc reads bytes in ascending address order, msb of each byte first
package epk_pkg;

   // ----------------------------------------------------------------
   // special function register addresses and fields
   // ----------------------------------------------------------------
   localparam logic [7:0]  SFR_PROG_CTRL   = 8'h8F;
   localparam logic [7:0]  SFR_MEM_KEY     = 8'hB7;
   localparam int          WE_BIT          = 0;
   localparam logic [7:0]  PROG_CTRL_RESET = 8'h00;
   localparam logic [7:0]  KEY_FIRST       = 8'hA5;
   localparam logic [7:0]  KEY_SECOND      = 8'hF1;

   // ----------------------------------------------------------------
   // lock state read codes
   // ----------------------------------------------------------------
   localparam logic [1:0]  LK_RD_LOCKED    = 2'h0;
   localparam logic [1:0]  LK_RD_FIRST     = 2'h1;
   localparam logic [1:0]  LK_RD_OPEN      = 2'h2;
   localparam logic [1:0]  LK_RD_DISABLED  = 2'h3;

   // ----------------------------------------------------------------
   // debug port register indices
   // ----------------------------------------------------------------
   localparam logic [2:0]  DBG_ADDR_REG    = 3'h0;
   localparam logic [2:0]  DBG_CRC_BYTE_0  = 3'h1;
   localparam logic [2:0]  DBG_CRC_BYTE_1  = 3'h2;
   localparam logic [2:0]  DBG_CRC_BYTE_2  = 3'h3;
   localparam logic [2:0]  DBG_CRC_BYTE_3  = 3'h4;
   localparam int          BUSY_BIT        = 7;

   // ----------------------------------------------------------------
   // crc constants
   // ----------------------------------------------------------------
   localparam logic [15:0] POLY16          = 16'h1021;
   localparam logic [31:0] POLY32          = 32'h04C11DB7;
   localparam logic [15:0] INIT16          = 16'h0000;
   localparam logic [31:0] INIT32          = 32'h00000000;
   localparam int          BLOCK_BYTES     = 256;
   localparam logic [7:0]  BLOCK_LOW       = 8'h00;
   localparam logic [15:0] FULL_START      = 16'h0000;

   typedef enum logic [1:0] {
      EPK_LK_LOCKED   = 2'b00,
      EPK_LK_FIRST    = 2'b01,
      EPK_LK_OPEN     = 2'b11,
      EPK_LK_DISABLED = 2'b10
   } epk_lock_t;

   typedef enum logic [1:0] {
      EPK_CRC_IDLE  = 2'b00,
      EPK_CRC_FETCH = 2'b01,
      EPK_CRC_ACC   = 2'b11
   } epk_crc_state_t;

endpackage

// ===== src/epk_core.sv
`timescale 1ns/1ps
module epk_core #(
   parameter int MEM_BYTES = 16384
) (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   // cpu special function register access
   input  wire logic [7:0]  sfr_addr_i,
   input  wire logic        sfr_wr_i,
   input  wire logic        sfr_rd_i,
   input  wire logic [7:0]  sfr_wdata_i,
   output logic      [7:0]  sfr_rdata_o,
   // debug port register access
   input  wire logic [2:0]  dbg_sel_i,
   input  wire logic        dbg_wr_i,
   input  wire logic        dbg_rd_i,
   input  wire logic [7:0]  dbg_wdata_i,
   output logic      [7:0]  dbg_rdata_o,
   output logic             busy_o,
   // program memory read port for crc
   output logic             mem_rd_o,
   output logic      [15:0] mem_addr_o,
   input  wire logic [7:0]  mem_rdata_i,
   // external move write from cpu
   input  wire logic        xw_wr_i,
   input  wire logic [15:0] xw_addr_i,
   input  wire logic [7:0]  xw_data_i,
   // program memory write port
   output logic             prog_wr_o,
   output logic      [15:0] prog_addr_o,
   output logic      [7:0]  prog_data_o,
   output logic             write_enable_o,
   output logic      [1:0]  lock_state_o
);

   initial begin
      if (MEM_BYTES < epk_pkg::BLOCK_BYTES || MEM_BYTES > 65536 ||
          (MEM_BYTES % epk_pkg::BLOCK_BYTES) != 0) begin
         $error("MEM_BYTES must be a multiple of 256 within 64 KiB");
      end
   end

   localparam logic [15:0] LAST_ADDR = 16'(MEM_BYTES - 1);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] epk_crc16(input logic [15:0] c,
                                             input logic [7:0]  b);
      logic [15:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[15] ^ b[i];
         r  = {r[14:0], 1'b0};
         if (fb) begin
            r = r ^ epk_pkg::POLY16; // [R12]
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] epk_crc32(input logic [31:0] c,
                                             input logic [7:0]  b);
      logic [31:0] r;
      logic        fb;
      r = c;
      for (int i = 7; i >= 0; i--) begin
         fb = r[31] ^ b[i]; // [R19]
         r  = {r[30:0], 1'b0};
         if (fb) begin
            r = r ^ epk_pkg::POLY32; // [R8]
         end
      end
      return r;
   endfunction

   function automatic logic [1:0] epk_lock_code(input epk_pkg::epk_lock_t s);
      logic [1:0] v;
      v = epk_pkg::LK_RD_LOCKED;
      unique case (s)
         epk_pkg::EPK_LK_LOCKED:   v = epk_pkg::LK_RD_LOCKED;
         epk_pkg::EPK_LK_FIRST:    v = epk_pkg::LK_RD_FIRST;
         epk_pkg::EPK_LK_OPEN:     v = epk_pkg::LK_RD_OPEN;
         epk_pkg::EPK_LK_DISABLED: v = epk_pkg::LK_RD_DISABLED;
      endcase
      return v;
   endfunction

   // ----------------------------------------------------------------
   // program store control
   // ----------------------------------------------------------------
   logic sfr_wr_ctrl;
   logic sfr_wr_key;
   logic we_q;

   assign sfr_wr_ctrl = sfr_wr_i && (sfr_addr_i == epk_pkg::SFR_PROG_CTRL);
   assign sfr_wr_key  = sfr_wr_i && (sfr_addr_i == epk_pkg::SFR_MEM_KEY);

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         we_q <= epk_pkg::PROG_CTRL_RESET[epk_pkg::WE_BIT];
      end else if (sfr_wr_ctrl) begin
         we_q <= sfr_wdata_i[epk_pkg::WE_BIT]; // [R14]
      end
   end

   // ----------------------------------------------------------------
   // lock and key
   // ----------------------------------------------------------------
   epk_pkg::epk_lock_t lock_q;
   logic               xw_prog;

   // move writes only aim at program memory while the enable bit is set
   assign xw_prog = xw_wr_i && we_q; // [R13]

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         lock_q <= epk_pkg::EPK_LK_LOCKED;
      end else if (lock_q == epk_pkg::EPK_LK_DISABLED) begin
         lock_q <= epk_pkg::EPK_LK_DISABLED; // [R17]
      end else if (xw_prog) begin
         // a write closes the lock again, a write while shut kills it
         if (lock_q == epk_pkg::EPK_LK_OPEN) begin
            lock_q <= epk_pkg::EPK_LK_LOCKED; // [R16]
         end else begin
            lock_q <= epk_pkg::EPK_LK_DISABLED; // [R17]
         end
      end else if (sfr_wr_key) begin
         unique case (lock_q)
            epk_pkg::EPK_LK_LOCKED: begin
               if (sfr_wdata_i == epk_pkg::KEY_FIRST) begin
                  lock_q <= epk_pkg::EPK_LK_FIRST; // [R15]
               end else begin
                  lock_q <= epk_pkg::EPK_LK_DISABLED; // [R17]
               end
            end
            epk_pkg::EPK_LK_FIRST: begin
               if (sfr_wdata_i == epk_pkg::KEY_SECOND) begin
                  lock_q <= epk_pkg::EPK_LK_OPEN; // [R15]
               end else begin
                  lock_q <= epk_pkg::EPK_LK_DISABLED; // [R17]
               end
            end
            epk_pkg::EPK_LK_OPEN: begin
               lock_q <= epk_pkg::EPK_LK_DISABLED; // [R17]
            end
            epk_pkg::EPK_LK_DISABLED: begin
               lock_q <= epk_pkg::EPK_LK_DISABLED;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         prog_wr_o   <= 1'b0;
         prog_addr_o <= 16'h0000;
         prog_data_o <= 8'h00;
      end else begin
         prog_wr_o <= xw_prog && (lock_q == epk_pkg::EPK_LK_OPEN); // [R13]
         if (xw_prog) begin
            prog_addr_o <= xw_addr_i;
            prog_data_o <= xw_data_i;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         write_enable_o <= 1'b0;
         lock_state_o   <= epk_pkg::LK_RD_LOCKED;
      end else begin
         write_enable_o <= we_q;
         lock_state_o   <= epk_lock_code(lock_q);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sfr_rdata_o <= 8'h00;
      end else if (sfr_rd_i) begin
         if (sfr_addr_i == epk_pkg::SFR_PROG_CTRL) begin
            sfr_rdata_o <= {7'h00, we_q}; // [R14]
         end else if (sfr_addr_i == epk_pkg::SFR_MEM_KEY) begin
            sfr_rdata_o <= {6'h00, epk_lock_code(lock_q)}; // [R18]
         end else begin
            sfr_rdata_o <= 8'h00;
         end
      end
   end

   // ----------------------------------------------------------------
   // crc engine
   // ----------------------------------------------------------------
   // no security input reaches this engine, so locked parts still verify
   epk_pkg::epk_crc_state_t crc_st_q;
   logic        wide_q;
   logic [15:0] addr_q;
   logic [15:0] last_q;
   logic [31:0] acc_q;
   logic [31:0] res_q;
   logic        start_blk;
   logic        start_full;
   logic        idle;

   assign idle       = (crc_st_q == epk_pkg::EPK_CRC_IDLE);
   // writes arriving while busy are dropped
   assign start_blk  = idle && dbg_wr_i &&
                       (dbg_sel_i == epk_pkg::DBG_CRC_BYTE_0); // [R1] [R10]
   assign start_full = idle && dbg_wr_i &&
                       (dbg_sel_i == epk_pkg::DBG_CRC_BYTE_1); // [R1] [R4]

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         crc_st_q <= epk_pkg::EPK_CRC_IDLE;
      end else begin
         unique case (crc_st_q)
            epk_pkg::EPK_CRC_IDLE: begin
               if (start_blk || start_full) begin
                  crc_st_q <= epk_pkg::EPK_CRC_FETCH; // [R2]
               end
            end
            epk_pkg::EPK_CRC_FETCH: begin
               crc_st_q <= epk_pkg::EPK_CRC_ACC;
            end
            epk_pkg::EPK_CRC_ACC: begin
               if (addr_q == last_q) begin
                  crc_st_q <= epk_pkg::EPK_CRC_IDLE;
               end else begin
                  crc_st_q <= epk_pkg::EPK_CRC_FETCH;
               end
            end
            default: begin
               crc_st_q <= epk_pkg::EPK_CRC_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         wide_q <= 1'b0;
         addr_q <= 16'h0000;
         last_q <= 16'h0000;
      end else if (start_blk) begin
         wide_q <= 1'b0;
         addr_q <= {dbg_wdata_i, epk_pkg::BLOCK_LOW}; // [R3] [R10]
         last_q <= {dbg_wdata_i, 8'hFF}; // [R3]
      end else if (start_full) begin
         wide_q <= 1'b1;
         addr_q <= epk_pkg::FULL_START; // [R5]
         last_q <= LAST_ADDR; // [R5]
      end else if (crc_st_q == epk_pkg::EPK_CRC_ACC && addr_q != last_q) begin
         addr_q <= addr_q + 16'h0001; // [R19]
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         acc_q <= 32'h00000000;
      end else if (start_blk) begin
         acc_q <= {16'h0000, epk_pkg::INIT16};
      end else if (start_full) begin
         acc_q <= epk_pkg::INIT32;
      end else if (crc_st_q == epk_pkg::EPK_CRC_ACC) begin
         if (wide_q) begin
            acc_q <= epk_crc32(acc_q, mem_rdata_i);
         end else begin
            acc_q <= {16'h0000, epk_crc16(acc_q[15:0], mem_rdata_i)}; // [R19]
         end
      end
   end

   // result lands once the last byte is folded in
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         res_q <= 32'h00000000;
      end else if (crc_st_q == epk_pkg::EPK_CRC_ACC && addr_q == last_q) begin
         if (wide_q) begin
            res_q <= epk_crc32(acc_q, mem_rdata_i); // [R7]
         end else begin
            res_q[15:0] <= epk_crc16(acc_q[15:0], mem_rdata_i); // [R11]
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         mem_rd_o   <= 1'b0;
         mem_addr_o <= 16'h0000;
         busy_o     <= 1'b0;
      end else begin
         mem_rd_o   <= (crc_st_q == epk_pkg::EPK_CRC_FETCH);
         mem_addr_o <= addr_q;
         busy_o     <= !idle; // [R6]
      end
   end

   // ----------------------------------------------------------------
   // debug read path
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         dbg_rdata_o <= 8'h00;
      end else if (dbg_rd_i) begin
         unique case (dbg_sel_i)
            epk_pkg::DBG_ADDR_REG:
               dbg_rdata_o <= 8'(!idle) << epk_pkg::BUSY_BIT; // [R6]
            epk_pkg::DBG_CRC_BYTE_0: dbg_rdata_o <= res_q[7:0]; // [R7] [R11]
            epk_pkg::DBG_CRC_BYTE_1: dbg_rdata_o <= res_q[15:8]; // [R11]
            epk_pkg::DBG_CRC_BYTE_2: dbg_rdata_o <= res_q[23:16];
            epk_pkg::DBG_CRC_BYTE_3: dbg_rdata_o <= res_q[31:24]; // [R7]
            default:                 dbg_rdata_o <= 8'h00;
         endcase
      end
   end

endmodule

// ===== dv/epk_core_props.sv
`timescale 1ns/1ps
module epk_core_props #(
   parameter int MEM_BYTES = 16384
) (
   input wire logic        clk_sys_i,
   input wire logic        reset_i,
   input wire logic [7:0]  sfr_addr_i,
   input wire logic        sfr_wr_i,
   input wire logic        sfr_rd_i,
   input wire logic [7:0]  sfr_wdata_i,
   input wire logic [7:0]  sfr_rdata_o,
   input wire logic [2:0]  dbg_sel_i,
   input wire logic        dbg_wr_i,
   input wire logic [7:0]  dbg_wdata_i,
   input wire logic        busy_o,
   input wire logic        mem_rd_o,
   input wire logic [15:0] mem_addr_o,
   input wire logic        xw_wr_i,
   input wire logic [15:0] xw_addr_i,
   input wire logic [7:0]  xw_data_i,
   input wire logic        prog_wr_o,
   input wire logic [15:0] prog_addr_o,
   input wire logic [7:0]  prog_data_o,
   input wire logic [1:0]  lock_state_o
);
   logic        pend_q;
   logic        blk_q;
   logic        first_q;
   logic [7:0]  hi_q;
   logic [15:0] last_q;
   int          run_q;
   logic        start_w;
   logic        key_w;
   // starts landing in the last busy cycle are not tracked
   assign start_w = dbg_wr_i && !busy_o && !pend_q && (dbg_sel_i == epk_pkg::DBG_CRC_BYTE_0
                    || dbg_sel_i == epk_pkg::DBG_CRC_BYTE_1);
   assign key_w = sfr_wr_i && sfr_addr_i == epk_pkg::SFR_MEM_KEY;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pend_q <= 1'b0;
         first_q <= 1'b0;
      end else if (start_w) begin
         pend_q <= 1'b1;
         first_q <= 1'b1;
         blk_q <= dbg_sel_i == epk_pkg::DBG_CRC_BYTE_0;
         hi_q <= dbg_wdata_i;
      end else begin
         if (busy_o) pend_q <= 1'b0;
         if (mem_rd_o) first_q <= 1'b0;
      end
   end
   always_ff @(posedge clk_sys_i) begin
      if (mem_rd_o) last_q <= mem_addr_o;
      run_q <= (reset_i || !busy_o) ? 0 : run_q + 1;
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (reset_i);
   a_busy_rise: assert property (start_w |-> ##[1:2] busy_o)
      else $error("busy flag missing after crc start");
   a_busy_span: assert property ($fell(busy_o) |->
      run_q inside {[2 * (blk_q ? 256 : MEM_BYTES) - 1 : 2 * (blk_q ? 256 : MEM_BYTES) + 1]})
      else $error("busy length does not match byte count");
   a_read_busy: assert property (mem_rd_o |-> busy_o)
      else $error("memory read outside busy");
   a_first_addr: assert property (mem_rd_o && first_q |-> mem_addr_o ==
      (blk_q ? {hi_q, epk_pkg::BLOCK_LOW} : epk_pkg::FULL_START))
      else $error("crc starts at wrong address");
   a_next_addr: assert property (mem_rd_o && !first_q |-> mem_addr_o == last_q + 16'h0001)
      else $error("crc address not ascending");
   a_block_page: assert property (mem_rd_o && blk_q |-> mem_addr_o[15:8] == hi_q)
      else $error("block crc left its block");
   a_read_gap: assert property (mem_rd_o |=> !mem_rd_o)
      else $error("memory reads back to back");
   a_prog_cause: assert property (prog_wr_o |-> $past(xw_wr_i) && prog_addr_o ==
      $past(xw_addr_i) && prog_data_o == $past(xw_data_i))
      else $error("program write without matching move write");
   a_lock_again: assert property (prog_wr_o |-> ##[1:2] lock_state_o == 2'h0)
      else $error("lock did not close after program write");
   a_stay_disabled: assert property (lock_state_o == 2'h3 |=> lock_state_o == 2'h3)
      else $error("disabled lock state left without reset");
   a_key_first: assert property (key_w && sfr_wdata_i == 8'hA5 && !xw_wr_i &&
      lock_state_o == 2'h0 && !$past(sfr_wr_i) && !$past(xw_wr_i) |-> ##2 lock_state_o == 2'h1)
      else $error("first key not accepted");
   a_ctrl_zero: assert property (sfr_rd_i && sfr_addr_i == 8'h8F |=>
      sfr_rdata_o[7:1] == 7'h00)
      else $error("control upper bits not zero");
   a_key_read: assert property (sfr_rd_i && sfr_addr_i == 8'hB7 |=>
      sfr_rdata_o[7:2] == 6'h00)
      else $error("key read upper bits not zero");
   c_block: cover property (start_w && dbg_sel_i == epk_pkg::DBG_CRC_BYTE_0);
   c_full: cover property (start_w && dbg_sel_i == epk_pkg::DBG_CRC_BYTE_1);
   c_prog: cover property (prog_wr_o);
   c_dead: cover property (lock_state_o == 2'h3);
endmodule
bind epk_core epk_core_props #(.MEM_BYTES(MEM_BYTES)) epk_core_props_inst (
   .clk_sys_i(clk_sys_i), .reset_i(reset_i), .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i),
   .sfr_rd_i(sfr_rd_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o),
   .dbg_sel_i(dbg_sel_i), .dbg_wr_i(dbg_wr_i), .dbg_wdata_i(dbg_wdata_i), .busy_o(busy_o),
   .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .xw_wr_i(xw_wr_i), .xw_addr_i(xw_addr_i),
   .xw_data_i(xw_data_i), .prog_wr_o(prog_wr_o), .prog_addr_o(prog_addr_o),
   .prog_data_o(prog_data_o), .lock_state_o(lock_state_o));

// ===== dv/epk_mem_model.sv
`timescale 1ns/1ps
module epk_mem_model (
   input  wire logic        clk_sys_i,
   input  wire logic        mem_rd_i,
   input  wire logic [15:0] mem_addr_i,
   output logic      [7:0]  mem_rdata_o
);
   logic [7:0] q = 8'h00;
   // the core folds the byte in at the edge that ends its read strobe, so data
   // stands only while the strobe is high; toggling junk shows a late sample
   assign mem_rdata_o = mem_rd_i ? (mem_addr_i[7:0] ^ {mem_addr_i[14:8], 1'b0} ^ 8'h5A) : q;
   always_ff @(posedge clk_sys_i) begin
      q <= ~q;
   end
endmodule

// ===== dv/epk_core_bench.sv
`timescale 1ns/1ps
module epk_core_bench;
   localparam int MEMB = 512;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic sfr_wr_i, sfr_rd_i, dbg_wr_i, dbg_rd_i, xw_wr_i, busy_o, mem_rd_o, prog_wr_o, we_o;
   logic [7:0] sfr_addr_i, sfr_wdata_i, sfr_rdata_o, dbg_wdata_i, dbg_rdata_o, mem_rdata_i;
   logic [7:0] xw_data_i, prog_data_o, v, pw_d;
   logic [2:0] dbg_sel_i;
   logic [15:0] mem_addr_o, xw_addr_i, prog_addr_o, pw_a;
   logic [1:0] lock_state_o;
   logic [31:0] exp;
   int err_count = 0;
   int checks = 0;
   int pw_n = 0;
   epk_core #(.MEM_BYTES(MEMB)) epk_core_inst (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
      .sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
      .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .dbg_sel_i(dbg_sel_i),
      .dbg_wr_i(dbg_wr_i), .dbg_rd_i(dbg_rd_i), .dbg_wdata_i(dbg_wdata_i),
      .dbg_rdata_o(dbg_rdata_o), .busy_o(busy_o), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o),
      .mem_rdata_i(mem_rdata_i), .xw_wr_i(xw_wr_i), .xw_addr_i(xw_addr_i),
      .xw_data_i(xw_data_i), .prog_wr_o(prog_wr_o), .prog_addr_o(prog_addr_o),
      .prog_data_o(prog_data_o), .write_enable_o(we_o), .lock_state_o(lock_state_o));
   epk_mem_model epk_mem_model_inst (.clk_sys_i(clk_sys_i), .mem_rd_i(mem_rd_o),
      .mem_addr_i(mem_addr_o), .mem_rdata_o(mem_rdata_i));
   initial begin
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   always @(posedge clk_sys_i) begin
      if (prog_wr_o === 1'b1) begin
         pw_n++;
         pw_a = prog_addr_o;
         pw_d = prog_data_o;
      end
   end
   function automatic logic [31:0] crc(input logic [15:0] base, input int n, input int w);
      logic [31:0] c;
      logic [15:0] a;
      c = 32'h0;
      for (int i = 0; i < n; i++) begin
         a = base + 16'(i);
         c ^= {24'h0, a[7:0] ^ {a[14:8], 1'b0} ^ 8'h5A} << (w - 8);
         for (int b = 0; b < 8; b++) begin
            c = c[w - 1] ? ((c << 1) ^ (w == 16 ? 32'h1021 : 32'h04C11DB7)) : (c << 1);
         end
      end
      return (w == 16) ? (c & 32'h0000FFFF) : c;
   endfunction
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] got);
      checks++;
      if (got !== e) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, e, got);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic do_reset();
      reset_i = 1'b1;
      repeat (10) @(negedge clk_sys_i);
      reset_i = 1'b0;
   endtask
   task automatic sfr(input logic [7:0] a, input logic [7:0] d, input logic rd);
      @(negedge clk_sys_i);
      {sfr_addr_i, sfr_wdata_i, sfr_wr_i, sfr_rd_i} = {a, d, !rd, rd};
      @(negedge clk_sys_i);
      {sfr_wr_i, sfr_rd_i} = 2'b00;
      v = sfr_rdata_o;
   endtask
   task automatic dbg(input logic [2:0] s, input logic [7:0] d, input logic rd);
      @(negedge clk_sys_i);
      {dbg_sel_i, dbg_wdata_i, dbg_wr_i, dbg_rd_i} = {s, d, !rd, rd};
      @(negedge clk_sys_i);
      {dbg_wr_i, dbg_rd_i} = 2'b00;
      v = dbg_rdata_o;
   endtask
   task automatic xw(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys_i);
      {xw_addr_i, xw_data_i, xw_wr_i} = {a, d, 1'b1};
      @(negedge clk_sys_i);
      xw_wr_i = 1'b0;
      repeat (2) @(negedge clk_sys_i);
   endtask
   task automatic wait_idle();
      repeat (4) @(negedge clk_sys_i);
      dbg(3'h0, 8'h00, 1'b1);
      chk("busy bit", 32'h1, v[7]);
      for (int i = 0; i < 3000 && busy_o !== 1'b0; i++) @(negedge clk_sys_i);
      if (busy_o !== 1'b0) begin
         err_count++;
         report_and_stop();
      end
      dbg(3'h0, 8'h00, 1'b1);
      chk("busy bit clear", 32'h0, v[7]);
   endtask
   initial begin
      {sfr_wr_i, sfr_rd_i, dbg_wr_i, dbg_rd_i, xw_wr_i} = 5'h00;
      {sfr_addr_i, sfr_wdata_i, dbg_wdata_i, xw_data_i, dbg_sel_i, xw_addr_i} = 51'h0;
      do_reset();
      // -----------------------------------------------------------
      // registers and key sequence
      // -----------------------------------------------------------
      sfr(8'h8F, 8'h00, 1'b1);
      chk("ctrl reset", 32'h00, v);
      sfr(8'h8F, 8'hFF, 1'b0);
      sfr(8'h8F, 8'h00, 1'b1);
      chk("ctrl upper bits", 32'h01, v);
      chk("write enable", 32'h1, we_o);
      sfr(8'h8F, 8'hFE, 1'b0);
      xw(16'h0123, 8'h3C);
      chk("write with enable off", 32'h0, pw_n);
      chk("write enable off", 32'h0, we_o);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("key reset", 32'h0, v);
      sfr(8'h8F, 8'h01, 1'b0);
      sfr(8'hB7, 8'hA5, 1'b0);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("first key", 32'h1, v);
      sfr(8'hB7, 8'hF1, 1'b0);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("unlocked", 32'h2, v);
      xw(16'h0345, 8'hC3);
      chk("program writes", 32'h1, pw_n);
      chk("program address", 32'h0345, pw_a);
      chk("program data", 32'hC3, pw_d);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("relocked", 32'h0, v);
      xw(16'h0010, 8'h11);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("write while locked", 32'h3, v);
      chk("blocked write", 32'h1, pw_n);
      do_reset();
      sfr(8'hB7, 8'hF1, 1'b0);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("second key first", 32'h3, v);
      sfr(8'hB7, 8'hA5, 1'b0);
      sfr(8'hB7, 8'h00, 1'b1);
      chk("disabled sticks", 32'h3, v);
      $display("test registers and keys done");
      // -----------------------------------------------------------
      // crc runs, the block one while writes are disabled
      // -----------------------------------------------------------
      dbg(epk_pkg::DBG_CRC_BYTE_0, 8'h01, 1'b0);
      wait_idle();
      exp = crc(16'h0100, 256, 16);
      dbg(epk_pkg::DBG_CRC_BYTE_0, 8'h00, 1'b1);
      chk("crc16 low", exp[7:0], v);
      dbg(epk_pkg::DBG_CRC_BYTE_1, 8'h00, 1'b1);
      chk("crc16 high", exp[15:8], v);
      do_reset();
      dbg(epk_pkg::DBG_CRC_BYTE_1, 8'h00, 1'b0);
      wait_idle();
      exp = crc(16'h0000, MEMB, 32);
      for (int k = 0; k < 4; k++) begin
         dbg(epk_pkg::DBG_CRC_BYTE_0 + 3'(k), 8'h00, 1'b1);
         chk("crc32 byte", exp[8 * k +: 8], v);
      end
      $display("test crc done");
      report_and_stop();
   end
endmodule
